// ---- dv/cpu_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module cpu_model (
    input wire logic mclk,
    output var flash_map_pkg::mem_req_t req,
    output logic [6:0] strb,
    output logic [7:0] wr_data,
    output logic fetch_from_ram
);
    initial
    begin
        req = '0;
        strb = 7'h00;
        wr_data = 8'h00;
        fetch_from_ram = 1'b0;
    end

    // strobe index: 0 staging, 1 commit, 2 standby, 3 sysmap,
    // 4 ram commit, 5 port ctrl, 6 interrupt entry
    task automatic reg_wr(input int s, input logic [7:0] d, input logic r);
        @(posedge mclk);
        strb <= 7'h01 << s;
        wr_data <= d;
        fetch_from_ram <= r;
        @(posedge mclk);
        strb <= 7'h00;
        // released data must not look like the last value
        wr_data <= ~d;
    endtask

    // an access is whole in one cycle, so no sequence is left open
    task automatic mem(input logic c, input logic w, input logic [15:0] a,
        input logic [7:0] d);
        @(posedge mclk);
        req <= {1'b1, c, w, a, d};
        @(posedge mclk);
        req <= {1'b0, ~c, ~w, ~a, ~d};
    endtask
endmodule

`default_nettype wire

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    localparam flash_map_pkg::region_t fl = flash_map_pkg::REG_FLASH;
    localparam flash_map_pkg::region_t rom = flash_map_pkg::REG_ROM;
    localparam flash_map_pkg::region_t ram = flash_map_pkg::REG_RAM;
    localparam flash_map_pkg::region_t none = flash_map_pkg::REG_NONE;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic serial_mode = 1'b0;
    flash_map_pkg::mem_req_t req;
    flash_map_pkg::mem_route_t route;
    logic [6:0] strb;
    logic [7:0] wr_data, staging_rd, monitor_rd, standby_rd, port_ctrl_rd;
    logic [7:0] flash_cmd_data;
    logic fetch_from_ram, flash_cmd_we, toggle_en, standby_bit;
    logic standby_reset, rx_en, tx_en, clk_en, oth_en;
    int errors = 0;
    int n_compared = 0;
    int cyc = 0;

    always #50 mclk = ~mclk;

    cpu_model cpu (.mclk(mclk), .req(req), .strb(strb), .wr_data(wr_data),
        .fetch_from_ram(fetch_from_ram));

    flash_protect_map_control dut (.mclk(mclk), .rst_n(rst_n),
        .serial_mode(serial_mode), .req(req),
        .fetch_from_ram(fetch_from_ram), .irq_take(strb[6]),
        .staging_wr(strb[0]), .commit_wr(strb[1]), .standby_wr(strb[2]),
        .sysmap_wr(strb[3]), .ram_commit_wr(strb[4]),
        .port_ctrl_wr(strb[5]), .wr_data(wr_data),
        .staging_rd(staging_rd), .monitor_rd(monitor_rd),
        .standby_rd(standby_rd), .port_ctrl_rd(port_ctrl_rd), .route(route),
        .flash_cmd_we(flash_cmd_we), .flash_cmd_data(flash_cmd_data),
        .toggle_en(toggle_en), .standby_bit(standby_bit),
        .standby_reset(standby_reset), .loader_rx_pin_en(rx_en),
        .loader_tx_pin_en(tx_en), .loader_clock_pin_en(clk_en),
        .other_port_input_en(oth_en));

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e)
        begin
            errors++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask

    task automatic wr(input int s, input logic [7:0] d, input logic r = 0);
        cpu.reg_wr(s, d, r);
        #1;
    endtask

    // route answers one cycle after the request edge
    task automatic acc(input logic c, input logic w, input logic [15:0] a,
        input flash_map_pkg::region_t e);
        cpu.mem(c, w, a, 8'h3C);
        #1;
        chk({6'h00, route.region}, {6'h00, e});
        chk({route.valid, route.addr[14:8]}, {1'b1, a[14:8]});
    endtask

    task automatic t_reset;
        chk(staging_rd, 8'h40);
        chk(monitor_rd, 8'h00);
        acc(1'b0, 1'b1, 16'hC555, fl);
        chk(flash_cmd_we, 1'b0);
        chk(toggle_en, 1'b0);
    endtask

    task automatic t_enable;
        wr(0, 8'hA0);
        chk(staging_rd, 8'hA0);
        chk(toggle_en, 1'b0);
        wr(1, 8'h55);
        chk(toggle_en, 1'b0);
        wr(1, 8'hD5);
        chk(monitor_rd, 8'h20);
        acc(1'b0, 1'b1, 16'hC555, fl);
        chk(flash_cmd_we, 1'b1);
        chk(flash_cmd_data, 8'h3C);
        acc(1'b1, 1'b1, 16'hC555, fl);
        chk(flash_cmd_we, 1'b0);
    endtask

    task automatic t_area;
        wr(0, 8'hA8);
        wr(1, 8'hD5);
        chk(monitor_rd, 8'h28);
        acc(1'b0, 1'b0, 16'hC000, fl);
        chk(route.code_bank, 1'b1);
        acc(1'b1, 1'b0, 16'hFFFF, fl);
        chk(route.code_bank, 1'b1);
        wr(0, 8'hA0);
        wr(1, 8'hD5);
        acc(1'b0, 1'b0, 16'hC000, fl);
        chk(route.code_bank, 1'b0);
    endtask

    task automatic t_boot;
        wr(0, 8'hB0);
        wr(1, 8'hD5);
        acc(1'b0, 1'b0, 16'h1000, rom);
        acc(1'b1, 1'b0, 16'h17FF, rom);
        acc(1'b0, 1'b0, 16'h1800, fl);
        wr(0, 8'h40);
        wr(1, 8'hD5);
        chk(toggle_en, 1'b0);
        acc(1'b0, 1'b0, 16'h1000, fl);
        acc(1'b0, 1'b1, 16'hC555, fl);
        chk(flash_cmd_we, 1'b0);
    endtask

    task automatic t_ram;
        wr(3, 8'h02);
        acc(1'b1, 1'b0, 16'h0040, none);
        wr(4, 8'hD4);
        acc(1'b1, 1'b0, 16'h083F, ram);
        wr(3, 8'h00);
        wr(4, 8'hD4);
        acc(1'b1, 1'b0, 16'h0040, none);
    endtask

    task automatic t_standby;
        wr(2, 8'h01);
        chk(standby_bit, 1'b0);
        wr(2, 8'h01, 1'b1);
        chk(standby_bit, 1'b1);
        chk(standby_rd, 8'h00);
        acc(1'b0, 1'b0, 16'hC000, fl);
        chk(standby_reset, 1'b1);
        wr(6, 8'h00);
        chk(standby_bit, 1'b0);
        wr(3, 8'h01);
        wr(4, 8'hD4);
        wr(2, 8'h01, 1'b1);
        wr(6, 8'h00);
        chk(standby_bit, 1'b1);
        wr(2, 8'h00, 1'b1);
        wr(3, 8'h00);
        wr(4, 8'hD4);
    endtask

    task automatic t_serial;
        @(posedge mclk);
        serial_mode <= 1'b1;
        @(posedge mclk);
        #1;
        chk({rx_en, tx_en, clk_en, oth_en}, 4'hC);
        wr(5, 8'h02);
        // enables follow the stored bits one edge after the write
        @(posedge mclk);
        #1;
        chk({clk_en, oth_en}, 2'h2);
        wr(5, 8'h03);
        @(posedge mclk);
        #1;
        chk(oth_en, 1'b1);
        chk(port_ctrl_rd, 8'h03);
        acc(1'b1, 1'b0, 16'h1C00, rom);
        acc(1'b0, 1'b0, 16'h1800, fl);
        acc(1'b1, 1'b0, 16'h0040, ram);
        wr(1, 8'hD5);
        chk(monitor_rd[4], 1'b1);
        @(posedge mclk);
        serial_mode <= 1'b0;
        wr(5, 8'h00);
        chk({clk_en, oth_en}, 2'h3);
        chk(port_ctrl_rd, 8'h00);
    endtask

    task automatic close_out;
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // the run needs about a hundred cycles; far beyond that means a hang
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            errors++;
            close_out();
        end
    end

    initial
    begin
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset();
        t_enable();
        t_area();
        t_boot();
        t_ram();
        t_standby();
        t_serial();
        close_out();
    end
endmodule

`default_nettype wire

// ---- logic/flash_map_pkg.sv ----
package flash_map_pkg;

    localparam logic [7:0] COMMIT_KEY = 8'hD5;
    localparam logic [7:0] RAM_COMMIT_KEY = 8'hD4;
    localparam logic [2:0] MODE_ENABLE = 3'h5;
    localparam logic [2:0] MODE_PROTECT = 3'h2;
    localparam logic [1:0] AREA_DEFAULT = 2'h0;
    localparam logic [1:0] AREA_CODE = 2'h2;
    localparam logic [7:0] STAGING_RESET = 8'h40;
    localparam logic [1:0] PORT_CTRL_RESET = 2'h0;

    // staging byte field positions
    localparam int MODE_MSB = 7;
    localparam int MODE_LSB = 5;
    localparam int BOOT_POS = 4;
    localparam int AREA_MSB = 3;
    localparam int AREA_LSB = 2;
    // monitor byte field positions
    localparam int MON_MODE_POS = 5;
    localparam int MON_BOOT_POS = 4;

    localparam logic [15:0] ROM_LO = 16'h1000;
    localparam logic [15:0] ROM_DATA_HI = 16'h17FF;
    localparam logic [15:0] ROM_CODE_SER_HI = 16'h1FFF;
    localparam logic [15:0] WIN_LO = 16'hC000;
    localparam logic [15:0] FLASH_LO = 16'h1000;
    localparam logic [15:0] RAM_LO = 16'h0040;
    localparam logic [15:0] RAM_HI = 16'h083F;

    typedef enum logic [1:0] {
        REG_NONE = 2'b00,
        REG_FLASH = 2'b01,
        REG_ROM = 2'b10,
        REG_RAM = 2'b11
    } region_t;

    typedef struct packed {
        logic [2:0] mode;
        logic boot;
        logic [1:0] area;
    } flash_fields_t;

    typedef struct packed {
        logic ram_sel;
        logic vec_ram;
    } sys_fields_t;

    typedef struct packed {
        logic valid;
        logic code;
        logic write;
        logic [15:0] addr;
        logic [7:0] wdata;
    } mem_req_t;

    typedef struct packed {
        logic valid;
        region_t region;
        logic code_bank;
        logic [15:0] addr;
    } mem_route_t;

endpackage

// ---- logic/flash_protect_map_control.sv ----
`timescale 1ns/1ps
`default_nettype none

module flash_protect_map_control (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic serial_mode,
    input wire flash_map_pkg::mem_req_t req,
    input wire logic fetch_from_ram,
    input wire logic irq_take,
    input wire logic staging_wr,
    input wire logic commit_wr,
    input wire logic standby_wr,
    input wire logic sysmap_wr,
    input wire logic ram_commit_wr,
    input wire logic port_ctrl_wr,
    input wire logic [7:0] wr_data,
    output logic [7:0] staging_rd,
    output logic [7:0] monitor_rd,
    output logic [7:0] standby_rd,
    output logic [7:0] port_ctrl_rd,
    output flash_map_pkg::mem_route_t route,
    output logic flash_cmd_we,
    output logic [7:0] flash_cmd_data,
    output logic toggle_en,
    output logic standby_bit,
    output logic standby_reset,
    output logic loader_rx_pin_en,
    output logic loader_tx_pin_en,
    output logic loader_clock_pin_en,
    output logic other_port_input_en
);

    typedef struct packed {
        logic [7:0] staging;
        flash_map_pkg::flash_fields_t active;
        flash_map_pkg::sys_fields_t sys_stage;
        flash_map_pkg::sys_fields_t sys_act;
        logic standby;
        logic [1:0] port_ctrl;
        flash_map_pkg::mem_route_t route;
        logic cmd_we;
        logic [7:0] cmd_data;
        logic stb_rst;
        logic clk_en;
        logic oth_en;
        logic tog;
    } state_t;

    typedef flash_map_pkg::flash_fields_t flash_fields_t;
    typedef flash_map_pkg::sys_fields_t sys_fields_t;

    state_t q;
    state_t d;
    flash_fields_t staged;
    logic enabled;
    logic boot_eff;
    logic ram_eff;
    logic in_win;
    logic is_flash;
    flash_map_pkg::region_t reg_sel;

    always_comb
    begin
        staged.mode = q.staging[flash_map_pkg::MODE_MSB:flash_map_pkg::MODE_LSB];
        staged.boot = q.staging[flash_map_pkg::BOOT_POS];
        staged.area = q.staging[flash_map_pkg::AREA_MSB:flash_map_pkg::AREA_LSB];
        enabled = (q.active.mode == flash_map_pkg::MODE_ENABLE);
        boot_eff = q.active.boot | serial_mode;
        ram_eff = q.sys_act.ram_sel | serial_mode;
        in_win = (req.addr >= flash_map_pkg::WIN_LO);
        reg_sel = flash_map_pkg::REG_NONE;
        if (req.addr >= flash_map_pkg::RAM_LO
            && req.addr <= flash_map_pkg::RAM_HI)
        begin
            // ram always in data space, in code only when mapped
            if (!req.code || ram_eff)
            begin
                reg_sel = flash_map_pkg::REG_RAM;
            end
        end
        else if (boot_eff && req.addr >= flash_map_pkg::ROM_LO
                 && req.addr <= flash_map_pkg::ROM_DATA_HI)
        begin
            reg_sel = flash_map_pkg::REG_ROM;
        end
        else if (serial_mode && req.code
                 && req.addr >= flash_map_pkg::ROM_LO
                 && req.addr <= flash_map_pkg::ROM_CODE_SER_HI)
        begin
            reg_sel = flash_map_pkg::REG_ROM;
        end
        else if (req.addr >= flash_map_pkg::FLASH_LO)
        begin
            reg_sel = flash_map_pkg::REG_FLASH;
        end
        is_flash = req.valid && (reg_sel == flash_map_pkg::REG_FLASH);
    end

    always_comb
    begin
        d = q;
        if (staging_wr)
        begin
            d.staging = wr_data;
        end
        // one key write moves every staged field at once
        if (commit_wr && wr_data == flash_map_pkg::COMMIT_KEY)
        begin
            d.active = staged;
        end
        if (sysmap_wr)
        begin
            d.sys_stage.ram_sel = wr_data[1];
            d.sys_stage.vec_ram = wr_data[0];
        end
        if (ram_commit_wr && wr_data == flash_map_pkg::RAM_COMMIT_KEY)
        begin
            d.sys_act = q.sys_stage;
        end
        if (standby_wr && fetch_from_ram)
        begin
            d.standby = wr_data[0];
        end
        // hardware clear on interrupt entry wins over a software write
        if (irq_take && !q.sys_act.vec_ram)
        begin
            d.standby = 1'b0;
        end
        if (port_ctrl_wr && serial_mode)
        begin
            d.port_ctrl = wr_data[1:0];
        end
        d.route.valid = req.valid;
        d.route.region = reg_sel;
        d.route.addr = req.addr;
        // reserved area codes fall back to the default mapping
        // upper data window resolves to code flash cells when switched
        d.route.code_bank = req.code
            || (in_win && q.active.area == flash_map_pkg::AREA_CODE);
        // only new writes are gated; a running sequence is not reset
        d.cmd_we = is_flash && req.write && !req.code && in_win
            && enabled && !q.standby;
        d.cmd_data = req.wdata;
        // one-cycle request; the reset block itself sits outside
        d.stb_rst = is_flash && q.standby;
        // enables follow the stored bits, one edge after a write
        d.clk_en = !serial_mode || q.port_ctrl[1];
        d.oth_en = !serial_mode || q.port_ctrl[0];
        if (!rst_n)
        begin
            d.staging = flash_map_pkg::STAGING_RESET;
            d.active.mode = flash_map_pkg::MODE_PROTECT;
            d.active.boot = 1'b0;
            d.active.area = flash_map_pkg::AREA_DEFAULT;
            d.sys_stage = '0;
            d.sys_act = '0;
            d.standby = 1'b0;
            d.port_ctrl = flash_map_pkg::PORT_CTRL_RESET;
            d.route = '0;
            d.cmd_we = 1'b0;
            d.cmd_data = 8'h00;
            d.stb_rst = 1'b0;
            d.clk_en = 1'b1;
            d.oth_en = 1'b1;
        end
        // registered so the pin shows no decode glitch
        d.tog = (d.active.mode == flash_map_pkg::MODE_ENABLE);
    end

    always_ff @(posedge mclk)
    begin
        q <= d;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            staging_rd <= flash_map_pkg::STAGING_RESET;
            monitor_rd <= 8'h00;
            standby_rd <= 8'h00;
            port_ctrl_rd <= 8'h00;
        end
        else
        begin
            staging_rd <= d.staging;
            monitor_rd <= {2'b00,
                d.active.mode == flash_map_pkg::MODE_ENABLE,
                d.active.boot | serial_mode, d.active.area, 2'b00};
            standby_rd <= 8'h00;
            port_ctrl_rd <= serial_mode ? {6'h00, d.port_ctrl} : 8'h00;
        end
    end

    assign route = q.route;
    assign flash_cmd_we = q.cmd_we;
    assign flash_cmd_data = q.cmd_data;
    // toggle reads follow the same protection as commands
    assign toggle_en = q.tog;
    assign standby_bit = q.standby;
    assign standby_reset = q.stb_rst;
    // the loader uart pins stay open in both modes
    assign loader_rx_pin_en = 1'b1;
    assign loader_tx_pin_en = 1'b1;
    assign loader_clock_pin_en = q.clk_en;
    assign other_port_input_en = q.oth_en;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // write protect and key commit
    key_commit_a: assert property (commit_wr && wr_data == 8'hD5
        |=> q.active == $past(staged))
        else $error("key did not copy staged fields");
    nonkey_hold_a: assert property (!(commit_wr && wr_data == 8'hD5)
        |=> $stable(q.active))
        else $error("active fields moved without key");
    stage_read_a: assert property (staging_wr
        |=> staging_rd == $past(wr_data))
        else $error("staged byte not read back");
    // the default disable would mask reset itself, so it is lifted here
    reset_protect_a: assert property (disable iff (1'b0)
        !rst_n |=> q.active.mode == 3'h2 && !toggle_en)
        else $error("protection not set after reset");
    enable_key_a: assert property (commit_wr && wr_data == 8'hD5
        && staged.mode == 3'h5 |=> toggle_en)
        else $error("commands not enabled by key");
    disable_key_a: assert property (commit_wr && wr_data == 8'hD5
        && staged.mode == 3'h2 |=> !toggle_en && !monitor_rd[5])
        else $error("commands not disabled by key");
    protect_block_a: assert property (q.active.mode != 3'h5
        |=> !flash_cmd_we)
        else $error("command passed while protected");
    code_write_a: assert property (req.valid && req.code
        |=> !flash_cmd_we)
        else $error("command through code space");
    cmd_pass_a: assert property (req.valid && req.write && !req.code
        && req.addr >= 16'hC000 && q.active.mode == 3'h5 && !q.standby
        |=> flash_cmd_we && flash_cmd_data == $past(req.wdata))
        else $error("enabled command write dropped");

    // address mapping
    area_code_a: assert property (req.valid && !req.code
        && req.addr >= 16'hC000 && q.active.area == 2'h2
        |=> route.code_bank)
        else $error("upper data window not switched");
    area_data_a: assert property (req.valid && !req.code
        && q.active.area == 2'h0 |=> !route.code_bank)
        else $error("data window not restored");
    ram_commit_a: assert property (ram_commit_wr && wr_data == 8'hD4
        |=> q.sys_act == $past(q.sys_stage))
        else $error("ram map key did not commit");
    ram_hold_a: assert property (!(ram_commit_wr && wr_data == 8'hD4)
        |=> $stable(q.sys_act))
        else $error("ram map moved without key");
    ram_code_a: assert property (req.valid && req.code
        && !serial_mode && !q.sys_act.ram_sel
        && req.addr >= 16'h0040 && req.addr <= 16'h083F
        |=> route.region == flash_map_pkg::REG_NONE)
        else $error("ram in code space without mapping");
    ser_ram_a: assert property (req.valid && req.code && serial_mode
        && req.addr >= 16'h0040 && req.addr <= 16'h083F
        |=> route.region == flash_map_pkg::REG_RAM)
        else $error("ram not mapped in serial mode");
    boot_rom_a: assert property (req.valid && q.active.boot
        && req.addr >= 16'h1000 && req.addr <= 16'h17FF
        |=> route.region == flash_map_pkg::REG_ROM)
        else $error("loader rom not shown");
    ser_rom_a: assert property (req.valid && req.code && serial_mode
        && req.addr >= 16'h1000 && req.addr <= 16'h1FFF
        |=> route.region == flash_map_pkg::REG_ROM)
        else $error("loader rom missing in serial mode");
    ser_data_a: assert property (req.valid && !req.code && serial_mode
        && req.addr >= 16'h1800 && req.addr <= 16'h1FFF
        |=> route.region == flash_map_pkg::REG_FLASH)
        else $error("loader rom too wide in data space");
    boot_ser_a: assert property (serial_mode
        |=> monitor_rd[4])
        else $error("boot select not one in serial");

    // standby control
    standby_ram_a: assert property (standby_wr && !fetch_from_ram
        && !irq_take |=> $stable(q.standby))
        else $error("standby written from flash code");
    standby_rst_a: assert property (req.valid && q.standby
        && reg_sel == flash_map_pkg::REG_FLASH |=> standby_reset)
        else $error("no standby reset on flash access");
    irq_clear_a: assert property (irq_take && !q.sys_act.vec_ram
        |=> !standby_bit)
        else $error("standby not cleared on interrupt");
    irq_keep_a: assert property (irq_take && q.sys_act.vec_ram
        && q.standby && !standby_wr |=> standby_bit)
        else $error("standby lost on ram vector interrupt");

    // port input gating
    ser_ports_a: assert property (serial_mode && $past(serial_mode)
        && !q.port_ctrl[0] |=> !other_port_input_en)
        else $error("ports open in serial mode");
    ser_clock_a: assert property (serial_mode && q.port_ctrl[1]
        |=> loader_clock_pin_en)
        else $error("clock input not reopened");
    mcu_ports_a: assert property (!serial_mode
        |=> other_port_input_en && loader_clock_pin_en
        && port_ctrl_rd == 8'h00)
        else $error("ports closed in mcu mode");
    mcu_port_wr_a: assert property (port_ctrl_wr && !serial_mode
        |=> $stable(q.port_ctrl))
        else $error("port control written in mcu mode");

    enable_c: cover property (commit_wr && wr_data == 8'hD5
        && staged.mode == 3'h5 ##1 toggle_en);
    cmd_c: cover property (flash_cmd_we);
    stb_c: cover property (standby_reset);
    remap_c: cover property (route.code_bank && !route.valid ##1 route.valid);
    rom_c: cover property (route.valid
        && route.region == flash_map_pkg::REG_ROM);

endmodule

`default_nettype wire
